// File: logic/key_export_consts.vh
`ifndef KEY_EXPORT_CONSTS_VH
`define KEY_EXPORT_CONSTS_VH
// lifecycle state codes on lifecycle_state input
`define LCS_CHIP_MAKER 2'h0
`define LCS_DEVICE_MAKER 2'h1
`define LCS_SECURED 2'h2
`define LCS_RETURN 2'h3
// test mode codes on test_mode input
`define TM_UNPROGRAMMED 2'h0
`define TM_TRUSTED 2'h1
`define TM_PRODUCTION 2'h2
// register byte offsets on the AHB-Lite slave
`define REG_FATAL_ERROR 12'h000
`define REG_STATUS 12'h004
`define REG_ZERO_COUNT_ERR 12'h008
`define FATAL_TRIGGER 32'hFA7A1EEE
`define KEY_STRIDE 8'h20
`define KEY_COUNT 3'h7
`define WORDS_PER_KEY 3'h7
`define HTRANS_NONSEQ_BIT 1
`endif

// File: logic/key_slot.v
`timescale 1ns/1ps
`include "key_export_consts.vh"
// one 256-bit key shadow register with its valid flag
module key_slot #(
  parameter KEY_W = 256
) (
  input wire hclk,
  input wire hresetn,
  input wire load,
  input wire [KEY_W-1:0] load_value,
  input wire kill,
  output reg valid,
  output reg [KEY_W-1:0] value
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid <= 1'b0;
      value <= {KEY_W{1'b0}};
    end else if (kill) begin
      valid <= 1'b0;
      value <= {KEY_W{1'b0}};
    end else if (load) begin
      valid <= 1'b1;
      value <= load_value;
    end
  end
endmodule // key_slot

// File: logic/apb_key_writer.v
`timescale 1ns/1ps
`include "key_export_consts.vh"
// apb manager for single 32-bit writes, one at a time
module apb_key_writer (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire [7:0] addr,
  input wire [31:0] data,
  output reg busy,
  output reg done,
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [7:0] paddr,
  output reg [31:0] pwdata,
  input wire pready
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h00000000;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= addr;
        pwdata <= data;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        pwdata <= 32'h00000000; // keep key bits off the idle bus
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // apb_key_writer

// File: logic/key_export.v
`timescale 1ns/1ps
`include "key_export_consts.vh"
module key_export #(
  parameter KEY_W = 256,
  parameter [KEY_W-1:0] EMBEDDED_KEY = {8{32'h5A5A0F0F}} // arbitrary
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire lifecycle_known,
  input wire [1:0] lifecycle_state,
  input wire [1:0] test_mode,
  input wire fatal_error_out,
  input wire otp_key_valid,
  input wire [6*KEY_W-1:0] otp_keys,
  input wire [5:0] otp_count_mismatch,
  output reg lifecycle_state_valid,
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [7:0] paddr,
  output reg [31:0] pwdata,
  input wire pready
);
  localparam ST_WAIT = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_SEND = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state;
  reg sw_fatal;
  reg [5:0] zero_count_err;
  reg [2:0] key_idx;
  reg [2:0] word_idx;
  reg req_pend;
  reg ph_valid;
  reg ph_write;
  reg [11:0] ph_addr;
  wire [6:0] key_valid;
  wire [7*KEY_W-1:0] key_flat;
  wire [6:0] kill;
  wire [6:0] may_export;
  wire [6:0] bad_otp;
  wire fatal_any;
  wire wr_busy;
  wire wr_done;
  reg wr_start;
  reg [31:0] wr_data;
  wire lcs_cm;
  wire lcs_dm;
  wire lcs_se;
  wire lcs_rt;
  wire tm_tr;
  wire tm_pr;
  wire tm_un;
  integer i;

  function all_same;
    input [KEY_W-1:0] k;
    begin
      all_same = (&k) | ~(|k);
    end
  endfunction

  assign lcs_cm = lifecycle_state == `LCS_CHIP_MAKER;
  assign lcs_dm = lifecycle_state == `LCS_DEVICE_MAKER;
  assign lcs_se = lifecycle_state == `LCS_SECURED;
  assign lcs_rt = lifecycle_state == `LCS_RETURN;
  assign tm_tr = test_mode == `TM_TRUSTED;
  assign tm_pr = test_mode == `TM_PRODUCTION;
  assign tm_un = test_mode == `TM_UNPROGRAMMED;
  assign fatal_any = sw_fatal | fatal_error_out;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : chk
      assign bad_otp[g+1] = all_same(otp_keys[g*KEY_W +: KEY_W]);
    end
  endgenerate
  assign bad_otp[0] = 1'b0;

  // kill terms per key class
  assign kill[0] = fatal_any | lcs_se | lcs_rt | tm_tr | tm_un;
  generate
    for (g = 1; g < 5; g = g + 1) begin : k14
      assign kill[g] = fatal_any | lcs_cm | lcs_rt | tm_un;
    end
    for (g = 5; g < 7; g = g + 1) begin : k56
      assign kill[g] = fatal_any | ~lcs_se | tm_un;
    end
  endgenerate

  assign may_export[0] = !fatal_any & key_valid[0] & (lcs_cm | lcs_dm)
    & tm_pr;
  generate
    for (g = 1; g < 5; g = g + 1) begin : e14
      assign may_export[g] = !fatal_any & key_valid[g] & (lcs_dm | lcs_se)
        & (tm_tr | tm_pr);
    end
    for (g = 5; g < 7; g = g + 1) begin : e56
      assign may_export[g] = !fatal_any & key_valid[g] & lcs_se
        & (tm_tr | tm_pr);
    end
  endgenerate

  // load pulse only in ST_LOAD, keys that fail the checks stay zero
  generate
    for (g = 0; g < 7; g = g + 1) begin : slot
      wire ld;
      wire [KEY_W-1:0] src;
      if (g == 0) begin : emb
        assign src = EMBEDDED_KEY;
        assign ld = state == ST_LOAD;
      end else begin : otp
        assign src = otp_keys[(g-1)*KEY_W +: KEY_W];
        assign ld = state == ST_LOAD && !bad_otp[g]
          && !otp_count_mismatch[g-1];
      end
      key_slot #(.KEY_W(KEY_W)) u_slot (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(ld),
        .load_value(src),
        .kill(kill[g]),
        .valid(key_valid[g]),
        .value(key_flat[g*KEY_W +: KEY_W])
      );
    end
  endgenerate

  // key words travel only to the apb writer and the top pwdata flop, never to hrdata
  always @* begin
    wr_data = key_flat[key_idx*KEY_W + word_idx*32 +: 32];
    wr_start = state == ST_SEND && !wr_busy && !req_pend
      && may_export[key_idx];
  end

  apb_key_writer u_wr (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(wr_start),
    .addr(key_idx * `KEY_STRIDE + {3'h0, word_idx, 2'h0}),
    .data(wr_data),
    .busy(wr_busy),
    .done(wr_done),
    .psel(),
    .penable(),
    .pwrite(),
    .paddr(),
    .pwdata(),
    .pready(pready)
  );

  // rebuild the apb phases from wr_start so top outputs come from flops
  reg busy_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h00000000;
      busy_q <= 1'b0;
    end else begin
      busy_q <= wr_busy;
      if (wr_start) begin
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= key_idx * `KEY_STRIDE + {3'h0, word_idx, 2'h0};
        pwdata <= wr_data;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        pwdata <= 32'h00000000;
      end
    end
  end

  // load and export sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_WAIT;
      key_idx <= 3'h0;
      word_idx <= 3'h0;
      req_pend <= 1'b0;
      lifecycle_state_valid <= 1'b0;
      zero_count_err <= 6'h00;
    end else begin
      case (state)
        ST_WAIT: begin
          if (lifecycle_known && (fatal_any || otp_key_valid))
            state <= ST_LOAD;
        end
        ST_LOAD: begin
          for (i = 0; i < 6; i = i + 1)
            if (bad_otp[i+1] && !kill[i+1] && !fatal_any)
              zero_count_err[i] <= 1'b1;
          key_idx <= 3'h0;
          word_idx <= 3'h0;
          state <= ST_SEND;
        end
        ST_SEND: begin
          if (wr_start)
            req_pend <= 1'b1;
          if (req_pend && wr_done) begin
            req_pend <= 1'b0;
            word_idx <= word_idx + 3'h1;
            if (word_idx == `WORDS_PER_KEY) begin
              word_idx <= 3'h0;
              key_idx <= key_idx + 3'h1;
              if (key_idx == `KEY_COUNT - 3'h1)
                state <= ST_DONE;
            end
          end else if (!req_pend && !wr_busy && !may_export[key_idx]) begin
            word_idx <= 3'h0;
            key_idx <= key_idx + 3'h1;
            if (key_idx == `KEY_COUNT - 3'h1)
              state <= ST_DONE;
          end
        end
        ST_DONE: begin
          lifecycle_state_valid <= 1'b1;
        end
        default: state <= ST_WAIT;
      endcase
    end
  end

  // ahb-lite slave, zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 12'h000;
      sw_fatal <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      if (hready) begin
        ph_valid <= hsel && htrans[`HTRANS_NONSEQ_BIT];
        ph_write <= hwrite;
        ph_addr <= haddr;
        if (hsel && htrans[`HTRANS_NONSEQ_BIT] && !hwrite) begin
          case (haddr)
            `REG_FATAL_ERROR: hrdata <= {31'h00000000, fatal_any};
            `REG_STATUS: hrdata <= {28'h0000000, lifecycle_state_valid,
              state == ST_SEND, busy_q, sw_fatal};
            `REG_ZERO_COUNT_ERR: hrdata <= {26'h0000000, zero_count_err};
            default: hrdata <= 32'h00000000;
          endcase
        end
      end
      if (ph_valid && ph_write && ph_addr == `REG_FATAL_ERROR
        && hwdata == `FATAL_TRIGGER)
        sw_fatal <= 1'b1;
    end
  end
endmodule // key_export

// File: dv/apb_key_sink.sv
`timescale 1ns/1ps
// key store on the far end of the export link; stalls at random
module apb_key_sink (
  input wire hclk,
  input wire hresetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output logic pready
);
  logic [31:0] mem [0:63];
  int count;
  // keys are only stored here, derivation is left to the owner
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 0;
      pready <= 1'b0;
    end else begin
      pready <= ($urandom % 2) == 0;
      if (psel && penable && pwrite && pready) begin
        mem[paddr[7:2]] <= pwdata;
        count <= count + 1;
      end
    end
  end
endmodule // apb_key_sink

// File: dv/key_export_assertions.sv
`timescale 1ns/1ps
module key_export_assertions (
  input wire hclk,
  input wire hresetn,
  input wire [1:0] lifecycle_state,
  input wire [1:0] test_mode,
  input wire fatal_error_out,
  input wire lifecycle_state_valid,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  chk_apb_phases: assert property (
    $rose(psel) |-> s_setup ##1 s_access) else $error("apb phase");
  chk_apb_hold: assert property (
    s_access and !pready |=>
    s_access and ($stable(paddr) && $stable(pwdata)))
    else $error("apb hold");
  chk_apb_release: assert property (
    s_access and pready |=> !psel) else $error("apb release");
  chk_word_addr: assert property (
    psel |-> pwrite && paddr[1:0] == 2'h0 && paddr <= 8'hDC)
    else $error("export address");
  chk_embedded_gate: assert property (
    psel && paddr < 8'h20 |-> lifecycle_state < 2'h2 && test_mode == 2'h2)
    else $error("embedded key gate");
  chk_otp_gate: assert property (
    psel && paddr >= 8'h20 |-> lifecycle_state inside {2'h1, 2'h2}
    && test_mode inside {2'h1, 2'h2}) else $error("otp key gate");
  chk_owner_gate: assert property (
    psel && paddr >= 8'hA0 |-> lifecycle_state == 2'h2)
    else $error("owner key gate");
  chk_fatal_quiet: assert property (
    fatal_error_out [*2] |-> !$rose(psel)) else $error("export in fatal");
  chk_export_first: assert property (
    psel |-> !lifecycle_state_valid) else $error("export after valid");
endmodule // key_export_assertions
bind key_export key_export_assertions u_chk (.hclk, .hresetn,
  .lifecycle_state, .test_mode, .fatal_error_out, .lifecycle_state_valid,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam [255:0] EK = {64'hF0E1D2C3B4A59687, 64'h78695A4B3C2D1E0F,
    64'h0F1E2D3C4B5A6978, 64'h8796A5B4C3D2E1F0};
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fatal_error_out = 0;
  logic lifecycle_known = 0, otp_key_valid = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0, lifecycle_state = 2'h0, test_mode = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, rd;
  logic [1535:0] otp_keys = 1536'h0;
  logic [5:0] otp_count_mismatch = 6'h00;
  wire hready, hreadyout, hresp, lifecycle_state_valid, psel, penable;
  wire pwrite, pready;
  wire [7:0] paddr;
  wire [31:0] hrdata, pwdata;
  int errors = 0, checks_done = 0;
  assign hready = hreadyout;
  initial forever #5 hclk = ~hclk;
  key_export #(.EMBEDDED_KEY(EK)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .lifecycle_known, .lifecycle_state, .test_mode, .fatal_error_out,
    .otp_key_valid, .otp_keys, .otp_count_mismatch, .lifecycle_state_valid,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready);
  apb_key_sink u_sink (.hclk, .hresetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready);
  task report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
    if (n > 50) begin
      errors++;
      report_and_stop;
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  function automatic logic gate(int k, logic [1:0] l, logic [1:0] t);
    if (k == 0) return l < 2'h2 && t == 2'h2;
    if (t != 2'h1 && t != 2'h2) return 1'b0;
    return k < 5 ? (l == 2'h1 || l == 2'h2) : l == 2'h2;
  endfunction
  // one cold start: random keys, at most one forced blank or full, then audit
  task run(input logic [1:0] l, input logic [1:0] t, input logic f);
    logic [1535:0] kk;
    logic [255:0] kv;
    logic [5:0] mm, zc;
    logic b, g;
    int n, cnt;
    for (n = 0; n < 48; n++) kk[n*32 +: 32] = $urandom;
    n = $urandom % 8;
    if (n > 0 && n < 7) kk[(n-1)*256 +: 256] = {256{n[0]}};
    mm = ($urandom % 3 == 0) ? 6'($urandom) : 6'h00;
    @(posedge hclk);
    hresetn <= 1'b0;
    lifecycle_known <= 1'b0;
    otp_key_valid <= 1'b0;
    lifecycle_state <= l;
    test_mode <= t;
    fatal_error_out <= f;
    otp_keys <= kk;
    otp_count_mismatch <= mm;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    lifecycle_known <= 1'b1;
    otp_key_valid <= 1'b1;
    n = 0;
    do @(posedge hclk); while (lifecycle_state_valid !== 1'b1 && n++ < 2000);
    if (n > 2000) begin
      errors++;
      report_and_stop;
    end
    cnt = 0;
    zc = 6'h00;
    for (int k = 0; k < 7; k++) begin
      kv = k ? kk[(k-1)*256 +: 256] : EK;
      b = k && (kv == {256{1'b0}} || kv == {256{1'b1}});
      g = gate(k, l, t) && !f;
      // error bit follows the kill terms, not the export gate
      if (b && !f && t != 2'h0 && (k < 5 ? l inside {2'h1, 2'h2}
          : l == 2'h2)) zc[k-1] = 1'b1;
      if (g && !b && !(k && mm[k-1])) begin
        cnt += 8;
        for (int w = 0; w < 8; w++)
          check(u_sink.mem[k*8+w], kv[w*32 +: 32]);
      end
    end
    check(u_sink.count, cnt);
    ahb(1'b0, 12'h008, 32'h0);
    check(rd & {26'h0, ~mm}, {26'h0, zc & ~mm});
  endtask
  initial begin
    void'($urandom(15843));
    run(2'h2, 2'h1, 1'b1);
    for (int i = 0; i < 16; i++) run(i[3:2], i[1:0], 1'b0);
    ahb(1'b1, 12'h000, 32'hFA7A1EEF);
    ahb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    ahb(1'b1, 12'h000, 32'hFA7A1EEE);
    ahb(1'b0, 12'h000, 32'h0);
    check(rd & 32'h1, 32'h1);
    check({31'h0, hresp}, 32'h0);
    ahb(1'b0, 12'h0FC, 32'h0);
    check(rd, 32'h0);
    report_and_stop;
  end
endmodule // tb_top
